// *** rtl/fsr_ctrl.sv ***
// suspend, resume, no-operation, software reset and four-wire exit command control with APB
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module fsr_ctrl import fsr_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] sio_in,
    output logic four_wire_command_mode,
    output logic busy,
    output logic soft_reset_pulse
);
    fsr_state_t s, n;
    fsr_frame_t frame;

    fsr_link u_link (
        .pclk(pclk),
        .presetn(presetn),
        .cs_n(cs_n),
        .sclk(sclk),
        .sio_in(sio_in),
        .quad(s.quad),
        .frame(frame)
    );

    always_comb begin
        logic erase_run;
        logic prog_run;
        logic suspended;
        logic allowed;
        logic opc_only;
        logic ok;
        logic [31:0] status;
        erase_run = (s.erase_left != '0) && !s.esus;
        prog_run = (s.prog_left != '0) && !s.psus;
        suspended = s.esus || s.psus;
        allowed = 1'b0;
        opc_only = 1'b0;
        ok = 1'b0;
        status = '0;
        n = s;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.rst_pulse = 1'b0;

        // internal write timers freeze while their operation is suspended
        if (erase_run) begin
            n.erase_left = s.erase_left - 1'b1;
        end
        if (prog_run) begin
            n.prog_left = s.prog_left - 1'b1;
        end

        // enhance mode switched on while suspended blocks resume until it is off
        if (!s.perf) begin
            n.perf_in_susp = 1'b0;
        end else if (suspended) begin
            n.perf_in_susp = 1'b1;
        end

        if (frame.done && frame.nbits != '0) begin
            opc_only = (frame.nbits == OPC_BITS);
            // any completed command other than the arm drops an armed reset
            n.arm = 1'b0;
            if (!suspended) begin
                allowed = 1'b1;
            end else if (susp_allowed(frame.op)) begin
                allowed = 1'b1;
            end else if (s.esus && !s.psus) begin
                // erase suspend lets write enable and programming of other banks through
                allowed = (frame.op == OP_WR_ENABLE) || (frame.op == OP_PP)
                    || (frame.op == OP_QPP);
            end
            if (allowed) begin
                unique case (frame.op)
                    OP_RST_ARM: begin
                        ok = opc_only;
                        n.arm = opc_only;
                    end
                    OP_RST: begin
                        if (opc_only && s.arm) begin
                            ok = 1'b1;
                            n.rst_pulse = 1'b1;
                            // volatile state back to power-on, running write abandoned
                            n.wr_latch = 1'b0;
                            n.esus = 1'b0;
                            n.psus = 1'b0;
                            n.quad = 1'b0;
                            n.perf = 1'b0;
                            n.perf_in_susp = 1'b0;
                            n.ebank = '0;
                            n.abort_prog = s.prog_left != '0;
                            n.erase_left = '0;
                            n.prog_left = '0;
                        end
                    end
                    OP_IDLE: begin
                        ok = opc_only;
                    end
                    OP_SUSPEND: begin
                        if (opc_only && prog_run) begin
                            ok = 1'b1;
                            n.psus = 1'b1;
                            n.wr_latch = 1'b0;
                        end else if (opc_only && erase_run) begin
                            ok = 1'b1;
                            n.esus = 1'b1;
                            n.wr_latch = 1'b0;
                        end
                    end
                    OP_RESUME: begin
                        // no write-enable check here on purpose
                        if (opc_only && suspended && !(s.perf && n.perf_in_susp)) begin
                            ok = 1'b1;
                            n.esus = 1'b0;
                            n.psus = 1'b0;
                        end
                    end
                    OP_WR_ENABLE: begin
                        ok = opc_only;
                        n.wr_latch = s.wr_latch || opc_only;
                    end
                    OP_ENTER_QUAD: begin
                        ok = opc_only;
                        n.quad = s.quad || opc_only;
                    end
                    OP_LEAVE_QUAD: begin
                        ok = opc_only;
                        n.quad = s.quad && !opc_only;
                    end
                    OP_SE: begin
                        if (s.wr_latch && !suspended && !erase_run && !prog_run
                            && frame.nbits == HEAD_BITS) begin
                            ok = 1'b1;
                            n.erase_left = ERASE_CYCLES;
                            n.ebank = bank_of(frame.addr);
                            n.wr_latch = 1'b0;
                        end
                    end
                    OP_PP, OP_QPP: begin
                        // the suspended erase bank must stay untouched
                        if (s.wr_latch && !erase_run && !prog_run && s.prog_left == '0
                            && frame.nbits >= MIN_PROG_BITS && frame.nbits[2:0] == 3'h0
                            && !(s.esus && bank_of(frame.addr) == s.ebank)) begin
                            ok = 1'b1;
                            n.prog_left = PROG_CYCLES;
                            n.wr_latch = 1'b0;
                        end
                    end
                    default: begin
                        ok = 1'b0;
                    end
                endcase
            end
            n.last_op = frame.op;
            n.last_nbits = frame.nbits;
            n.last_ok = ok;
            n.last_rej = !ok;
        end

        // status word, suspend flags at bits 2 and 3
        status[ST_BUSY] = s.busy;
        status[ST_WR_LATCH] = s.wr_latch;
        status[ST_PSUS] = s.psus;
        status[ST_ESUS] = s.esus;
        status[ST_QUAD] = s.quad;
        status[ST_PERF] = s.perf;
        status[ST_ARM] = s.arm;
        status[ST_BANK_LSB +: 3] = s.ebank;
        status[ST_ABORT] = s.abort_prog;
        status[ST_PERF_HOLD] = s.perf_in_susp;

        // apb: data and error registered in setup, ready shown in the first access cycle
        if (psel && !penable) begin
            n.pready = 1'b1;
            n.prdata = '0;
            unique case (paddr)
                REG_STATUS: n.prdata = status;
                REG_CTRL: n.prdata[CTRL_PERF] = s.perf;
                REG_CMD: begin
                    n.prdata[7:0] = s.last_op;
                    n.prdata[CMD_OK] = s.last_ok;
                    n.prdata[CMD_REJ] = s.last_rej;
                    n.prdata[CMD_NBITS_LSB +: 6] = s.last_nbits;
                end
                default: n.pslverr = 1'b1;
            endcase
        end
        // writes take effect only at the completing edge
        if (psel && penable && s.pready && pwrite && paddr == REG_CTRL && !n.rst_pulse) begin
            n.perf = pwdata[CTRL_PERF];
        end
        // a reset that aborts a program in the same cycle wins over the clear
        if (psel && penable && s.pready && pwrite && paddr == REG_STATUS && !n.rst_pulse) begin
            n.abort_prog = 1'b0;
        end

        n.busy = ((n.erase_left != '0) && !n.esus) || ((n.prog_left != '0) && !n.psus);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign four_wire_command_mode = s.quad;
    assign busy = s.busy;
    assign soft_reset_pulse = s.rst_pulse;
endmodule

// *** rtl/fsr_pkg.sv ***
// package with opcodes, register map, field positions, timing counts and carrier types
package fsr_pkg;

    // opcodes
    localparam logic [7:0] OP_SUSPEND = 8'hB0;
    localparam logic [7:0] OP_RESUME = 8'h30;
    localparam logic [7:0] OP_IDLE = 8'h00;
    localparam logic [7:0] OP_RST_ARM = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_LEAVE_QUAD = 8'hF5;
    localparam logic [7:0] OP_ENTER_QUAD = 8'h35;
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_QPP = 8'h38;
    localparam logic [7:0] OP_SE = 8'h20;

    // frame lengths in bits
    localparam logic [5:0] OPC_BITS = 6'h08;
    localparam logic [5:0] HEAD_BITS = 6'h20;
    localparam logic [5:0] MIN_PROG_BITS = 6'h28;
    localparam logic [5:0] CNT_SAT = 6'h3F;

    // bank field of a 24-bit address, one bank per 512 KiB
    localparam int BANK_LSB = 19;
    localparam int BANK_MSB = 21;

    // internal operation durations in pclk cycles
    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] ERASE_CYCLES = 20'h007D0;
    localparam logic [CNT_W-1:0] PROG_CYCLES = 20'h000C8;

    // register byte offsets
    localparam logic [11:0] REG_STATUS = 12'h000;
    localparam logic [11:0] REG_CTRL = 12'h004;
    localparam logic [11:0] REG_CMD = 12'h008;

    // status field positions
    localparam int ST_BUSY = 0;
    localparam int ST_WR_LATCH = 1;
    localparam int ST_PSUS = 2;
    localparam int ST_ESUS = 3;
    localparam int ST_QUAD = 4;
    localparam int ST_PERF = 5;
    localparam int ST_ARM = 6;
    localparam int ST_BANK_LSB = 8;
    localparam int ST_ABORT = 11;
    localparam int ST_PERF_HOLD = 12;

    // control and last-command field positions
    localparam int CTRL_PERF = 0;
    localparam int CMD_OK = 8;
    localparam int CMD_REJ = 9;
    localparam int CMD_NBITS_LSB = 16;

    typedef struct packed {
        logic done;
        logic [5:0] nbits;
        logic [7:0] op;
        logic [23:0] addr;
    } fsr_frame_t;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic [3:0] sio_s1;
        logic [3:0] sio_s2;
        logic wide;
        logic [5:0] cnt;
        logic [7:0] op;
        logic [23:0] addr;
        fsr_frame_t frame;
    } fsr_link_t;

    localparam fsr_link_t LINK_RST = '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, default: '0};

    typedef struct packed {
        logic wr_latch;
        logic esus;
        logic psus;
        logic quad;
        logic perf;
        logic perf_in_susp;
        logic arm;
        logic abort_prog;
        logic [2:0] ebank;
        logic [CNT_W-1:0] erase_left;
        logic [CNT_W-1:0] prog_left;
        logic [7:0] last_op;
        logic [5:0] last_nbits;
        logic last_ok;
        logic last_rej;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic busy;
        logic rst_pulse;
    } fsr_state_t;

    // opcodes taken without condition while suspended
    function automatic logic susp_allowed(input logic [7:0] op);
        case (op)
            8'h03, 8'h0B, 8'hBB, 8'hEB, 8'hE7, 8'h9F, 8'hAF, 8'h90, 8'h05, 8'h2B, 8'hB1,
            8'hC1, 8'h5A, 8'h3C, 8'h30, 8'h66, 8'h99, 8'hC0, 8'h35, 8'hF5, 8'h00,
            8'hAB: susp_allowed = 1'b1;
            default: susp_allowed = 1'b0;
        endcase
    endfunction

    function automatic logic [2:0] bank_of(input logic [23:0] addr);
        bank_of = addr[BANK_MSB:BANK_LSB];
    endfunction

endpackage

// *** rtl/fsr_link.sv ***
// serial command receiver: pin synchronisers, clock edge finding, opcode and address capture
`timescale 1ns/100ps
module fsr_link import fsr_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] sio_in,
    input wire logic quad,
    output fsr_frame_t frame
);
    fsr_link_t s, n;

    always_comb begin
        logic [3:0] bits;
        logic [2:0] step;
        logic [6:0] sum;
        bits = '0;
        step = '0;
        sum = '0;
        n = s;
        n.cs_s1 = cs_n;
        n.cs_s2 = s.cs_s1;
        n.cs_s3 = s.cs_s2;
        n.sclk_s1 = sclk;
        n.sclk_s2 = s.sclk_s1;
        n.sclk_s3 = s.sclk_s2;
        n.sio_s1 = sio_in;
        n.sio_s2 = s.sio_s1;
        n.frame.done = 1'b0;
        if (s.cs_s3 && !s.cs_s2) begin
            n.cnt = '0;
            n.wide = quad;
            n.op = '0;
            n.addr = '0;
        end else if (!s.cs_s2 && s.sclk_s2 && !s.sclk_s3) begin
            // single-wire mode looks only at line 0; upper lines are ignored
            bits = s.wide ? s.sio_s2 : {3'h0, s.sio_s2[0]};
            step = s.wide ? 3'h4 : 3'h1;
            if (s.cnt < OPC_BITS) begin
                n.op = s.wide ? {s.op[3:0], bits} : {s.op[6:0], bits[0]};
            end else if (s.cnt < HEAD_BITS) begin
                n.addr = s.wide ? {s.addr[19:0], bits} : {s.addr[22:0], bits[0]};
            end
            sum = {1'b0, s.cnt} + {4'h0, step};
            n.cnt = (sum > {1'b0, CNT_SAT}) ? CNT_SAT : sum[5:0];
            // the four-line program sends its address on all four lines
            if (n.cnt == OPC_BITS && n.op == OP_QPP) begin
                n.wide = 1'b1;
            end
        end
        if (!s.cs_s3 && s.cs_s2) begin
            n.frame.done = 1'b1;
            n.frame.nbits = s.cnt;
            n.frame.op = s.op;
            n.frame.addr = s.addr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= LINK_RST;
        end else begin
            s <= n;
        end
    end

    assign frame = s.frame;
endmodule

// *** verification/fsr_ctrl_props.sv ***
// concurrent checks on the ports of the suspend, resume and reset command controller
`timescale 1ns/100ps
module fsr_ctrl_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] sio_in,
    input wire logic four_wire_command_mode,
    input wire logic busy,
    input wire logic soft_reset_pulse
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    // commands act only once the synced select has been high for a while
    sequence s_frame_closed;
        cs_n && $past(cs_n, 2);
    endsequence
    a_apb_answer: assert property (s_setup |=> s_answer)
        else $error("apb answer not one cycle after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    a_reset_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("reset pulse longer than one cycle");
    a_reset_after_frame: assert property (soft_reset_pulse |-> s_frame_closed)
        else $error("reset pulse inside a frame");
    a_reset_clears_state: assert property (soft_reset_pulse |=> !busy && !four_wire_command_mode)
        else $error("state survives software reset");
    a_mode_at_frame_end: assert property ($changed(four_wire_command_mode) |-> s_frame_closed)
        else $error("command mode changed inside a frame");
    a_busy_at_frame_end: assert property ($rose(busy) |-> cs_n)
        else $error("busy rose inside a frame");
endmodule

// *** verification/fsr_host_model.sv ***
// host serial controller model driving select, serial clock and data lines
`timescale 1ns/100ps
module fsr_host_model import fsr_pkg::*; #(
    parameter int SUSP_GAP_NS = 18000,
    parameter int RESUME_GAP_NS = 2000
) (
    output logic cs_n,
    output logic sclk,
    output logic [3:0] sio_in
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sio_in = 4'h0;
    end
    // opcode, 24-bit address, then data, msb first; clock stands low between frames
    task automatic send(input logic [7:0] op, input logic [23:0] adr, input int nbits,
                        input logic wide);
        logic [63:0] v;
        int i;
        v = {op, adr, 32'hA5C3_5A3C};
        cs_n = 1'b0;
        #200;
        for (i = 0; i < nbits; i += (wide ? 4 : 1)) begin
            // unused upper lines 1 and 3 toggle so a design that reads them is caught
            sio_in = wide ? v[63-i -: 4] : {sio_in[3:1] ^ 3'h5, v[63-i]};
            #200 sclk = 1'b1;
            #200 sclk = 1'b0;
        end
        #200 cs_n = 1'b1;
        sio_in = ~sio_in;
        #(op == OP_SUSPEND ? SUSP_GAP_NS : (op == OP_RESUME ? RESUME_GAP_NS : 400));
    endtask
endmodule

// *** verification/fsr_ctrl_tb.sv ***
// self-checking bench for the suspend, resume and reset command controller
`timescale 1ns/100ps
`define CHK(a, x) begin checked++; if ((a) !== (x)) begin n_errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (x)); end end
module fsr_ctrl_tb import fsr_pkg::*; ;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, wq;
    logic cs_n, sclk, quad, busy, rst_p;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] sio_in;
    int n_errors = 0;
    int checked = 0;
    int n_rst = 0;
    fsr_ctrl i_fsr_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in),
        .four_wire_command_mode(quad), .busy(busy), .soft_reset_pulse(rst_p));
    fsr_host_model i_fsr_host_model (.cs_n(cs_n), .sclk(sclk), .sio_in(sio_in));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) if (rst_p === 1'b1) n_rst++;
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 16) begin
            n_errors++;
            final_report();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(q & m, x)
    endtask
    task automatic fr(input logic [7:0] op, input logic [23:0] a = 24'h00_0000, input int n = 8);
        i_fsr_host_model.send(op, a, n, wq);
    endtask
    // polling busy rather than waiting a fixed time keeps the bench free of latency guesses
    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 5000) begin
            @(posedge pclk);
            k++;
        end
        if (k == 5000) begin
            n_errors++;
            final_report();
        end
    endtask
    task automatic t_regs();
        rd(REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        apb(1'b1, REG_CMD, 32'hFFFF_FFFF);
        rd(REG_CMD, 32'hFFFF_FFFF, 32'h0000_0000);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        `CHK(e, 1'b1)
    endtask
    task automatic t_erase_susp();
        fr(OP_WR_ENABLE);
        fr(OP_SE, 24'h10_0000, 32);
        `CHK(busy, 1'b1)
        fr(OP_SUSPEND);
        rd(REG_STATUS, 32'h0000_070F, 32'h0000_0208);
        fr(OP_WR_ENABLE);
        fr(OP_PP, 24'h17_FFF8, 40);
        rd(REG_CMD, 32'h003F_03FF, 32'h0028_0202);
        fr(OP_WR_ENABLE);
        fr(OP_PP, 24'h38_0000, 40);
        rd(REG_CMD, 32'h003F_03FF, 32'h0028_0102);
        wait_idle();
        fr(8'hD8, 24'h00_0000, 32);
        rd(REG_CMD, 32'h003F_03FF, 32'h0020_02D8);
        fr(OP_RESUME);
        rd(REG_STATUS, 32'h0000_000D, 32'h0000_0001);
        wait_idle();
    endtask
    task automatic t_prog_susp();
        fr(OP_ENTER_QUAD);
        wq = 1'b1;
        `CHK(quad, 1'b1)
        fr(OP_WR_ENABLE);
        fr(OP_PP, 24'h00_0100, 40);
        fr(OP_SUSPEND);
        rd(REG_STATUS, 32'h0000_000F, 32'h0000_0004);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        fr(OP_RESUME);
        rd(REG_STATUS, 32'h0000_100C, 32'h0000_1004);
        apb(1'b1, REG_CTRL, 32'h0000_0000);
        fr(OP_RESUME);
        rd(REG_STATUS, 32'h0000_000D, 32'h0000_0001);
        // waiting the full program time instead of polling must also see it finished
        repeat (PROG_CYCLES) @(posedge pclk);
        `CHK(busy, 1'b0)
        fr(OP_LEAVE_QUAD);
        wq = 1'b0;
        `CHK(quad, 1'b0)
    endtask
    task automatic t_soft_reset();
        fr(OP_RST_ARM);
        rd(REG_STATUS, 32'h0000_0040, 32'h0000_0040);
        fr(OP_IDLE);
        rd(REG_STATUS, 32'h0000_0040, 32'h0000_0000);
        fr(OP_RST);
        `CHK(n_rst, 0)
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        fr(OP_WR_ENABLE);
        fr(OP_SE, 24'h00_0000, 32);
        fr(OP_RST_ARM);
        fr(OP_RST);
        `CHK(n_rst, 1)
        `CHK(busy, 1'b0)
        rd(REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
        fr(OP_WR_ENABLE);
        fr(OP_PP, 24'h00_0200, 40);
        fr(OP_RST_ARM);
        fr(OP_RST);
        rd(REG_STATUS, 32'h0000_0801, 32'h0000_0800);
        // the design sets no recovery time after an aborted program; the wait only delays the flag clear
        repeat (PROG_CYCLES) @(posedge pclk);
        apb(1'b1, REG_STATUS, 32'h0000_0000);
        rd(REG_STATUS, 32'h0000_0800, 32'h0000_0000);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        wq = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        t_regs();
        t_erase_susp();
        t_prog_susp();
        t_soft_reset();
        final_report();
    end
    // whole run is well under this; a hang ends in the same report
    initial begin
        #2000000;
        n_errors++;
        final_report();
    end
endmodule
bind fsr_ctrl fsr_ctrl_props i_fsr_ctrl_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in),
    .four_wire_command_mode(four_wire_command_mode), .busy(busy),
    .soft_reset_pulse(soft_reset_pulse));
